/* File: hdl/sdlc_loop_access_control.sv */
// loop access control of one serial channel: repeat, seize, transmit, pin drivers
//
// Summary of operation
// - no loop seizure unless go active set
// - turn seventh one of end-poll into zero
// - sending state breaks receive-to-transmit repeat
// - while sending, send frames whenever transmit fifo holds data
// - fill gaps with flags, ignoring time fill
// - leave sending at a flag gap with empty fifo and go active cleared
// - go on loop adds/removes one-bit delay
// - driver select: zero open drain, one push-pull
// - same driver choice on swapped receive pin
//
// Design decisions made here: the register offsets and strobed register access.
`default_nettype none
`include "sdlc_loop_consts.svh"

module sdlc_loop_access_control #(
    parameter int BIT_CYCLES = 8,
    parameter int FIFO_DEPTH = 16
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // register port
    input wire sdlc_loop_pkg::reg_req_t i_req,
    output logic [7:0] o_rd_data,
    // transmit data pin
    input wire logic i_txd_pin,
    output sdlc_loop_pkg::pin_drive_t o_txd_drv,
    // receive data pin
    input wire logic i_rxd_pin,
    output sdlc_loop_pkg::pin_drive_t o_rxd_drv
);
    import sdlc_loop_pkg::*;

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    localparam int AW = $clog2(FIFO_DEPTH);
    localparam int CW = $clog2(BIT_CYCLES);
    if (BIT_CYCLES < 2)
    begin : g_bad_bit
        $error("BIT_CYCLES must be at least 2");
    end
    if (FIFO_DEPTH < 2 || (1 << AW) != FIFO_DEPTH)
    begin : g_bad_depth
        $error("FIFO_DEPTH must be a power of two, at least 2");
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // zero then six ones already seen, seventh one arriving
    function automatic logic is_end_poll(input logic [6:0] hist, input logic bit_v);
        is_end_poll = (hist == `END_POLL_PREFIX) && bit_v;
    endfunction : is_end_poll

    // pin drive for a data bit; push-pull or open drain
    function automatic pin_drive_t drive_pin(input logic bit_v, input logic push_pull);
        drive_pin.out = push_pull ? bit_v : 1'b0;
        drive_pin.oe_n = push_pull ? 1'b0 : bit_v;
    endfunction : drive_pin

    // ----------------------------------------------------------------
    // registers and state
    // ----------------------------------------------------------------
    logic [7:0] cfg_q, cfg_d; // channel_config_one
    logic [7:0] ctl_q, ctl_d; // loop enable and pin swap
    logic [7:0] rd_q, rd_d; // read data
    logic [2:0] txs_sync_q, txs_sync_d; // txd pin synchroniser
    logic [2:0] rxs_sync_q, rxs_sync_d; // rxd pin synchroniser
    logic txd_lvl_q, txd_lvl_d; // filtered txd pin level
    logic rxd_lvl_q, rxd_lvl_d; // filtered rxd pin level
    logic [CW-1:0] cnt_q, cnt_d; // bit period counter
    loop_state_t loop_q, loop_d; // loop participation
    tx_state_t txs_q, txs_d; // transmitter activity
    logic [6:0] hist_q, hist_d; // last received bits, newest low
    logic tx_bit_q, tx_bit_d; // bit on the line while on loop
    logic [2:0] flag_idx_q, flag_idx_d; // flag bit position
    logic [7:0] sh_q, sh_d; // byte being sent
    logic [2:0] bit_idx_q, bit_idx_d; // data bit position
    logic [2:0] ones_q, ones_d; // run of ones for stuffing
    logic last_q, last_d; // byte closes a frame
    logic done_q, done_d; // byte fully shifted
    logic [AW:0] wp_q, wp_d; // fifo write pointer
    logic [AW:0] rp_q, rp_d; // fifo read pointer
    logic valid_q, valid_d; // head word readable
    pin_drive_t txd_q, txd_d; // txd pin drive
    pin_drive_t rxd_q, rxd_d; // rxd pin drive

    // combinational helpers
    logic bit_stb; // one cycle per bit
    logic rx_bit; // received line level
    logic swap; // serial pins flipped
    logic loop_en; // loop mode selected
    logic go_active_eff; // effective go active on loop
    logic go_on_eff; // effective go on loop
    logic eop_hit; // end-of-poll seventh one now
    logic push; // fifo write
    logic pop; // fifo read
    logic load; // start next byte
    logic full; // fifo full
    logic empty; // fifo empty
    logic line_bit; // bit the pin carries
    fifo_word_t head; // fifo head word
    fifo_word_t wr_word; // word being queued

    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    // writes, read data one cycle later, unmapped reads zero
    always_comb
    begin
        cfg_d = cfg_q;
        ctl_d = ctl_q;
        rd_d = `RST_BYTE;
        if (i_req.wr && i_req.addr == `OFS_CFG_ONE)
        begin
            cfg_d = i_req.wdata;
        end
        else if (i_req.wr && i_req.addr == `OFS_LOOP_CTL)
        begin
            ctl_d = {6'h00, i_req.wdata[1:0]};
        end
        if (i_req.rd && i_req.addr == `OFS_CFG_ONE)
        begin
            rd_d = cfg_q;
        end
        else if (i_req.rd && i_req.addr == `OFS_LOOP_CTL)
        begin
            rd_d = ctl_q;
        end
        else if (i_req.rd && i_req.addr == `OFS_STATUS)
        begin
            rd_d = {4'h0, full, ~valid_q, loop_q == LS_SEND, loop_q != LS_OFF};
        end
    end

    // loop bits count only in loop mode
    assign swap = ctl_q[`CTL_SWAP_BIT];
    assign loop_en = ctl_q[`CTL_LOOP_EN_BIT];
    assign go_active_eff = loop_en & cfg_q[`CFG_GO_ACTIVE_BIT];
    assign go_on_eff = loop_en & cfg_q[`CFG_GO_ON_BIT];

    // ----------------------------------------------------------------
    // pin input synchronisers and bit timing
    // ----------------------------------------------------------------
    // level changes once second and third stage agree
    always_comb
    begin
        txs_sync_d = {txs_sync_q[1:0], i_txd_pin};
        rxs_sync_d = {rxs_sync_q[1:0], i_rxd_pin};
        txd_lvl_d = (txs_sync_q[1] == txs_sync_q[2]) ? txs_sync_q[2] : txd_lvl_q;
        rxd_lvl_d = (rxs_sync_q[1] == rxs_sync_q[2]) ? rxs_sync_q[2] : rxd_lvl_q;
        cnt_d = bit_stb ? '0 : cnt_q + CW'(1);
    end
    assign bit_stb = (cnt_q == CW'(BIT_CYCLES - 1));
    assign rx_bit = swap ? txd_lvl_q : rxd_lvl_q;
    assign eop_hit = is_end_poll(hist_q, rx_bit);

    // ----------------------------------------------------------------
    // transmit fifo
    // ----------------------------------------------------------------
    assign full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
    assign empty = (wp_q == rp_q);
    assign push = i_req.wr && !full
        && (i_req.addr == `OFS_TX_DATA || i_req.addr == `OFS_TX_LAST);
    assign wr_word = '{last: i_req.addr == `OFS_TX_LAST, data: i_req.wdata};

    // pointers; head valid in the same cycle the registered memory read settles
    always_comb
    begin
        wp_d = push ? wp_q + (AW+1)'(1) : wp_q;
        rp_d = pop ? rp_q + (AW+1)'(1) : rp_q;
        valid_d = !empty && !pop;
    end

    loop_fifo_mem #(
        .WIDTH($bits(fifo_word_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_mem (
        .i_mclk(i_mclk),
        .i_wr_en(push),
        .i_wr_addr(wp_q[AW-1:0]),
        .i_wr_data(wr_word),
        .i_rd_addr(rp_q[AW-1:0]),
        .o_rd_data(head)
    );

    // ----------------------------------------------------------------
    // loop state and transmitter
    // ----------------------------------------------------------------
    // all moves happen on the bit strobe
    always_comb
    begin
        loop_d = loop_q;
        txs_d = txs_q;
        hist_d = hist_q;
        tx_bit_d = tx_bit_q;
        flag_idx_d = flag_idx_q;
        sh_d = sh_q;
        bit_idx_d = bit_idx_q;
        ones_d = ones_q;
        last_d = last_q;
        done_d = done_q;
        load = 1'b0;
        pop = 1'b0;
        if (bit_stb)
        begin
            hist_d = {hist_q[5:0], rx_bit};
            case (loop_q)
                LS_OFF:
                begin
                    if (eop_hit && go_on_eff)
                    begin
                        loop_d = LS_ON;
                        tx_bit_d = rx_bit;
                    end
                end
                LS_ON:
                begin
                    // repeat one bit late
                    tx_bit_d = rx_bit;
                    if (eop_hit && go_active_eff)
                    begin
                        tx_bit_d = 1'b0;
                        loop_d = LS_SEND;
                        txs_d = TX_FLAG;
                        flag_idx_d = 3'h0;
                    end
                    else if (eop_hit && !go_on_eff)
                    begin
                        loop_d = LS_OFF;
                    end
                end
                default:
                begin
                    case (txs_q)
                        TX_FLAG:
                        begin
                            if (flag_idx_q != 3'h0)
                            begin
                                tx_bit_d = 1'(`FLAG_PATTERN >> flag_idx_q);
                                flag_idx_d = flag_idx_q + 3'h1;
                            end
                            else if (valid_q)
                            begin
                                load = 1'b1;
                            end
                            else if (!go_active_eff)
                            begin
                                loop_d = LS_ON;
                                tx_bit_d = rx_bit;
                            end
                            else
                            begin
                                tx_bit_d = 1'(`FLAG_PATTERN);
                                flag_idx_d = 3'h1;
                            end
                        end
                        default:
                        begin
                            if (ones_q == `STUFF_LIMIT)
                            begin
                                tx_bit_d = 1'b0;
                                ones_d = 3'h0;
                            end
                            else if (done_q && !last_q && valid_q)
                            begin
                                load = 1'b1;
                            end
                            else if (done_q)
                            begin
                                txs_d = TX_FLAG;
                                tx_bit_d = 1'(`FLAG_PATTERN);
                                flag_idx_d = 3'h1;
                            end
                            else
                            begin
                                tx_bit_d = sh_q[bit_idx_q];
                                ones_d = sh_q[bit_idx_q] ? ones_q + 3'h1 : 3'h0;
                                bit_idx_d = bit_idx_q + 3'h1;
                                done_d = (bit_idx_q == `LAST_BIT_IDX);
                            end
                        end
                    endcase
                end
            endcase
            // take the head byte and send its first bit
            if (load)
            begin
                pop = 1'b1;
                txs_d = TX_DATA;
                sh_d = head.data;
                last_d = head.last;
                tx_bit_d = head.data[0];
                ones_d = head.data[0] ? 3'h1 : 3'h0;
                bit_idx_d = 3'h1;
                done_d = 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // pin drivers
    // ----------------------------------------------------------------
    // off loop the pin follows receive with no bit delay
    assign line_bit = (loop_q == LS_OFF) ? rx_bit : tx_bit_q;
    always_comb
    begin
        txd_d = '{out: 1'b0, oe_n: 1'b1};
        rxd_d = '{out: 1'b0, oe_n: 1'b1};
        // only the pin that carries transmit is driven, the other stays released
        if (swap)
        begin
            rxd_d = drive_pin(line_bit, cfg_q[`CFG_DRV_SEL_BIT]);
        end
        else
        begin
            txd_d = drive_pin(line_bit, cfg_q[`CFG_DRV_SEL_BIT]);
        end
    end

    // ----------------------------------------------------------------
    // state registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            cfg_q <= `RST_BYTE;
            ctl_q <= `RST_BYTE;
            rd_q <= `RST_BYTE;
            txs_sync_q <= 3'h7;
            rxs_sync_q <= 3'h7;
            txd_lvl_q <= 1'b1;
            rxd_lvl_q <= 1'b1;
            cnt_q <= '0;
            loop_q <= LS_OFF;
            txs_q <= TX_FLAG;
            hist_q <= 7'h00;
            tx_bit_q <= 1'b1;
            flag_idx_q <= 3'h0;
            sh_q <= `RST_BYTE;
            bit_idx_q <= 3'h0;
            ones_q <= 3'h0;
            last_q <= 1'b0;
            done_q <= 1'b0;
            wp_q <= '0;
            rp_q <= '0;
            valid_q <= 1'b0;
            txd_q <= '{out: 1'b0, oe_n: 1'b1};
            rxd_q <= '{out: 1'b0, oe_n: 1'b1};
        end
        else
        begin
            cfg_q <= cfg_d;
            ctl_q <= ctl_d;
            rd_q <= rd_d;
            txs_sync_q <= txs_sync_d;
            rxs_sync_q <= rxs_sync_d;
            txd_lvl_q <= txd_lvl_d;
            rxd_lvl_q <= rxd_lvl_d;
            cnt_q <= cnt_d;
            loop_q <= loop_d;
            txs_q <= txs_d;
            hist_q <= hist_d;
            tx_bit_q <= tx_bit_d;
            flag_idx_q <= flag_idx_d;
            sh_q <= sh_d;
            bit_idx_q <= bit_idx_d;
            ones_q <= ones_d;
            last_q <= last_d;
            done_q <= done_d;
            wp_q <= wp_d;
            rp_q <= rp_d;
            valid_q <= valid_d;
            txd_q <= txd_d;
            rxd_q <= rxd_d;
        end
    end
    assign o_rd_data = rd_q;
    assign o_txd_drv = txd_q;
    assign o_rxd_drv = rxd_q;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);

    sequence s_seize;
        bit_stb && loop_q == LS_ON && eop_hit && go_active_eff;
    endsequence
    sequence s_gap;
        bit_stb && loop_q == LS_SEND && txs_q == TX_FLAG && flag_idx_q == 3'h0;
    endsequence

    property p_no_seize_idle;
        $rose(loop_q == LS_SEND) |-> $past(go_active_eff);
    endproperty
    a_no_seize_idle: assert property (p_no_seize_idle) else $error("seized without go active");
    property p_flag_zero;
        s_seize |=> !tx_bit_q && loop_q == LS_SEND;
    endproperty
    a_flag_zero: assert property (p_flag_zero) else $error("seventh one not zeroed");
    property p_no_repeat;
        bit_stb && loop_q == LS_SEND && txs_q == TX_FLAG && flag_idx_q == 3'h1 |=> tx_bit_q;
    endproperty
    a_no_repeat: assert property (p_no_repeat) else $error("sending line not flag");
    property p_send_data;
        s_gap and valid_q |=> txs_q == TX_DATA ##[1:2] !valid_q || rp_q != $past(rp_q, 2);
    endproperty
    a_send_data: assert property (p_send_data) else $error("data not started");
    property p_flag_fill;
        s_gap and (!valid_q && go_active_eff) |=> txs_q == TX_FLAG && flag_idx_q == 3'h1
            && !tx_bit_q;
    endproperty
    a_flag_fill: assert property (p_flag_fill) else $error("gap not flag filled");
    property p_leave_send;
        $fell(loop_q == LS_SEND) |-> $past(!valid_q && !go_active_eff && txs_q == TX_FLAG)
            && loop_q == LS_ON;
    endproperty
    a_leave_send: assert property (p_leave_send) else $error("left sending early");
    property p_go_on;
        bit_stb && loop_q == LS_OFF && eop_hit && go_on_eff |=> loop_q == LS_ON [*2];
    endproperty
    a_go_on: assert property (p_go_on) else $error("on loop not entered");
    property p_open_drain;
        !$past(cfg_q[`CFG_DRV_SEL_BIT]) && !$past(swap) |-> !o_txd_drv.out;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open drain drove high");
    property p_swap_drv;
        $past(swap) && $past(cfg_q[`CFG_DRV_SEL_BIT]) |-> !o_rxd_drv.oe_n && o_txd_drv.oe_n;
    endproperty
    a_swap_drv: assert property (p_swap_drv) else $error("swapped pin not push-pull");
    property p_mode_gate;
        $past(!loop_en && loop_q == LS_OFF) |-> loop_q == LS_OFF;
    endproperty
    a_mode_gate: assert property (p_mode_gate) else $error("loop left off without mode");
endmodule : sdlc_loop_access_control

`default_nettype wire

/* File: pkg/sdlc_loop_consts.svh */
// offsets, field positions, reset values and patterns of the loop access block
`ifndef SDLC_LOOP_CONSTS_SVH
`define SDLC_LOOP_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_CFG_ONE 8'h00
`define OFS_LOOP_CTL 8'h01
`define OFS_STATUS 8'h02
`define OFS_TX_DATA 8'h03
`define OFS_TX_LAST 8'h04

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CFG_GO_ACTIVE_BIT 6
`define CFG_GO_ON_BIT 5
`define CFG_DRV_SEL_BIT 4
`define CFG_TIME_FILL_BIT 3
`define CTL_LOOP_EN_BIT 0
`define CTL_SWAP_BIT 1

// ----------------------------------------------------------------
// reset values and line patterns
// ----------------------------------------------------------------
`define RST_BYTE 8'h00
`define FLAG_PATTERN 8'h7e
`define END_POLL_PREFIX 7'h3f
`define STUFF_LIMIT 3'h5
`define LAST_BIT_IDX 3'h7

`endif

/* File: pkg/sdlc_loop_pkg.sv */
// types shared by the loop access block and its bench
`default_nettype none

package sdlc_loop_pkg;
    // one register bus request
    typedef struct packed
    {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    // participation of the channel on the loop
    typedef enum logic [1:0] {LS_OFF, LS_ON, LS_SEND} loop_state_t;

    // transmitter activity while sending on loop
    typedef enum logic {TX_FLAG, TX_DATA} tx_state_t;

    // drive of one serial pin
    typedef struct packed
    {
        logic out;
        logic oe_n;
    } pin_drive_t;

    // one queued transmit byte
    typedef struct packed
    {
        logic last;
        logic [7:0] data;
    } fifo_word_t;
endpackage : sdlc_loop_pkg

`default_nettype wire

/* File: hdl/loop_fifo_mem.sv */
// storage array of the transmit fifo with registered read data
`default_nettype none

module loop_fifo_mem #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    // clock
    input wire logic i_mclk,
    // write side
    input wire logic i_wr_en,
    input wire logic [$clog2(DEPTH)-1:0] i_wr_addr,
    input wire logic [WIDTH-1:0] i_wr_data,
    // read side
    input wire logic [$clog2(DEPTH)-1:0] i_rd_addr,
    output logic [WIDTH-1:0] o_rd_data
);
    // array of words
    logic [WIDTH-1:0] mem_q [DEPTH];

    // write the array and register the addressed word
    always_ff @(posedge i_mclk)
    begin
        if (i_wr_en)
        begin
            mem_q[i_wr_addr] <= i_wr_data;
        end
        o_rd_data <= mem_q[i_rd_addr];
    end
endmodule : loop_fifo_mem

`default_nettype wire

/* File: bench/loop_station.sv */
// upstream ring station model that polls the device
`default_nettype none

module loop_station #(
    parameter int BIT_CYCLES = 4
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // line toward the device
    output logic o_line
);
    timeunit 1ns;
    timeprecision 1ns;
    int cyc_q; // cycles into the bit
    logic [3:0] pos_q; // bit in the poll cycle
    // one zero then fifteen ones: every cycle ends in an end-of-poll pattern
    always @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            cyc_q <= 0;
            pos_q <= 4'h0;
        end
        else if (cyc_q == BIT_CYCLES - 1)
        begin
            cyc_q <= 0;
            pos_q <= pos_q + 4'h1;
        end
        else
            cyc_q <= cyc_q + 1;
    end
    assign o_line = (pos_q != 4'h0);
endmodule : loop_station

`default_nettype wire

/* File: bench/tb_top.sv */
// self-checking bench of the loop access block
`default_nettype none
`include "sdlc_loop_consts.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import sdlc_loop_pkg::*;
    localparam int BC = 4; // clocks per line bit
    logic i_mclk = 1'b0;
    logic i_sys_rst = 1'b1;
    reg_req_t i_req = '0;
    logic [7:0] o_rd_data;
    pin_drive_t o_txd_drv;
    pin_drive_t o_rxd_drv;
    logic st_line; // station bit
    logic swap_q = 1'b0; // bench copy of pin swap
    logic ods_q = 1'b0; // bench copy of driver select
    logic txd_lvl;
    logic rxd_lvl;
    logic tx_wire; // wire that carries transmit
    int err_count = 0;
    int checks_done = 0;
    int seed = 7393;
    int cyc_count = 0;
    logic [7:0] v;
    logic [7:0] r;
    logic [7:0] sh;
    logic found;
    // released pins read high through the pull-up
    assign txd_lvl = o_txd_drv.oe_n ? 1'b1 : o_txd_drv.out;
    assign rxd_lvl = o_rxd_drv.oe_n ? 1'b1 : o_rxd_drv.out;
    assign tx_wire = swap_q ? rxd_lvl : txd_lvl;

    sdlc_loop_access_control #(.BIT_CYCLES(BC), .FIFO_DEPTH(16)) dut (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_req(i_req),
        .o_rd_data(o_rd_data),
        .i_txd_pin(swap_q ? st_line : txd_lvl),
        .o_txd_drv(o_txd_drv),
        .i_rxd_pin(swap_q ? rxd_lvl : st_line),
        .o_rxd_drv(o_rxd_drv)
    );
    loop_station #(.BIT_CYCLES(BC)) station (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .o_line(st_line)
    );

    always #5 i_mclk = ~i_mclk;

    // hang guard
    always @(posedge i_mclk)
    begin
        cyc_count++;
        if (cyc_count == 40000)
        begin
            err_count++;
            end_sim();
        end
    end

    task automatic end_sim();
        if (err_count == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim

    // status byte expected from the register map
    function automatic logic [7:0] exp_status(input logic onl, input logic snd,
        input logic emp, input logic ful);
        exp_status = {4'h0, ful, emp, snd, onl};
    endfunction : exp_status

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_mclk);
        i_req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_mclk);
        i_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_mclk);
        i_req.rd <= 1'b0;
        @(negedge i_mclk);
        d = o_rd_data;
    endtask : rd

    // poll status until the masked bits match, bounded
    task automatic wait_st(input logic [7:0] m, input logic [7:0] e, input string nm);
        int n;
        n = 0;
        rd(`OFS_STATUS, r);
        while ((r & m) !== e && n < 300)
        begin
            rd(`OFS_STATUS, r);
            n++;
        end
        chk(nm, e, r & m);
    endtask : wait_st

    // shift k line bits in lsb first, look for byte p, watch the drivers
    task automatic seek(input logic [7:0] p, input int k, input string nm);
        pin_drive_t cd;
        pin_drive_t od;
        found = 1'b0;
        sh = ~p;
        repeat (k)
        begin
            repeat (BC) @(negedge i_mclk);
            cd = swap_q ? o_rxd_drv : o_txd_drv;
            od = swap_q ? o_txd_drv : o_rxd_drv;
            sh = {tx_wire, sh[7:1]};
            if (sh === p)
                found = 1'b1;
            if (ods_q)
                chk("push_pull_oe_n", 8'h00, {7'h0, cd.oe_n});
            else
                chk("open_drain_out", 8'h00, {7'h0, cd.out});
            chk("idle_pin_oe_n", 8'h01, {7'h0, od.oe_n});
        end
        chk(nm, 8'h01, {7'h0, found});
    endtask : seek

    initial
    begin
        repeat (4) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        rd(`OFS_CFG_ONE, v);
        chk("cfg_reset", `RST_BYTE, v);
        rd(`OFS_STATUS, v);
        chk("status_reset", exp_status(1'b0, 1'b0, 1'b1, 1'b0), v);
        rd(8'h05, v);
        chk("unmapped", 8'h00, v);
        wr(`OFS_LOOP_CTL, 8'hfc);
        rd(`OFS_LOOP_CTL, v);
        chk("ctl_upper", 8'h00, v);
        r = 8'($random(seed));
        wr(`OFS_CFG_ONE, r);
        rd(`OFS_CFG_ONE, v);
        chk("cfg_rw", r, v);
        // loop bits set but loop mode off
        wr(`OFS_CFG_ONE, 8'h70);
        ods_q <= 1'b1;
        repeat (40 * BC) @(posedge i_mclk);
        rd(`OFS_STATUS, v);
        chk("ignored_loop", 8'h00, v & 8'h03);
        wr(`OFS_CFG_ONE, 8'h30);
        wr(`OFS_LOOP_CTL, 8'h01);
        wait_st(8'h03, 8'h01, "enter_on_loop");
        wr(`OFS_CFG_ONE, 8'h70);
        wait_st(8'h02, 8'h02, "enter_sending");
        seek(`FLAG_PATTERN, 24, "gap_flags");
        wr(`OFS_TX_DATA, 8'h00);
        wr(`OFS_TX_DATA, 8'h00);
        wr(`OFS_TX_LAST, 8'h00);
        seek(8'h00, 40, "frame_sent");
        wait_st(8'h04, 8'h04, "fifo_drained");
        wr(`OFS_CFG_ONE, 8'h20);
        ods_q <= 1'b0;
        wait_st(8'h03, 8'h01, "leave_sending");
        seek(8'hfe, 40, "repeat_end_poll");
        // push-pull on the swapped pin
        wr(`OFS_CFG_ONE, 8'h30);
        ods_q <= 1'b1;
        wr(`OFS_LOOP_CTL, 8'h03);
        swap_q <= 1'b1;
        seek(8'hfe, 40, "swapped_repeat");
        wr(`OFS_CFG_ONE, 8'h00);
        wait_st(8'h01, 8'h00, "leave_on_loop");
        // off loop nothing drains: random bytes fill the queue, the extra one is dropped
        repeat (16 + 1)
        begin
            wr(`OFS_TX_DATA, 8'($random(seed)));
        end
        rd(`OFS_STATUS, v);
        chk("fifo_full", exp_status(1'b0, 1'b0, 1'b0, 1'b1), v);
        end_sim();
    end
endmodule : tb_top

`default_nettype wire
